// ---- pcd_far_model.sv ----
// Downstream consumer model for the sample stream of the datapath
`timescale 1ns/10ps
// ==================================================
// Stream consumer that the bench can stall
module pcd_far_model (
   input wire logic ref_clk,
   input wire logic stall,
   input wire logic path_valid,
   output logic path_ready,
   output int n_taken
);
   initial path_ready = 1'b0;
   initial n_taken = 0;
   // Ready moves on the falling edge so it never races the sampling edge
   always @(negedge ref_clk) begin
      path_ready <= !stall;
   end
   // A word changes hands only where valid and ready meet at a rising edge
   always @(posedge ref_clk) begin
      if (path_valid && path_ready) begin
         n_taken <= n_taken + 1;
      end
   end
endmodule // pcd_far_model

// ---- pcd_fifo.sv ----
// Parameterised FIFO with registered read data
`timescale 1ns/10ps
module pcd_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 32
) (
   input wire logic ref_clk,
   input wire logic rst,
   pcd_stream_if.snk in_s,
   pcd_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ovalid;
      logic [W-1:0] odata;
   } pcd_fifo_t;
   pcd_fifo_t r, next_r;
   logic [W-1:0] mem [DEPTH];
   logic full;
   logic push;
   logic load;
   // ==================================================
   // Flow control: full is exact so back-pressure reaches the source
   assign full = (r.cnt == (AW+1)'(DEPTH));
   assign push = in_s.valid & ~full;
   assign load = (r.cnt != '0) & (~r.ovalid | out_s.ready);
   assign in_s.ready = ~full;
   assign out_s.valid = r.ovalid;
   assign out_s.data = r.odata;
   // Next state of pointers, count and output register
   always_comb begin
      next_r = r;
      if (push) begin
         next_r.wp = r.wp + 1'b1;
      end
      if (load) begin
         next_r.rp = r.rp + 1'b1;
         next_r.odata = mem[r.rp];
         next_r.ovalid = 1'b1;
      end else if (out_s.ready) begin
         next_r.ovalid = 1'b0;
      end
      next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(load);
   end
   // Storage has no reset; the pointers, count and output register take one
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[r.wp] <= in_s.data;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule // pcd_fifo

// ---- pcd_pkg.sv ----
// Shared constants and types of the phase channel datapath
package pcd_pkg;
   // ==================================================
   // Timing
   localparam int CLK_HZ = 40_000_000;
   localparam int SAMPLE_SPS = 8_000;
   localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_SPS;
   typedef logic [12:0] pcd_div_t;
   // ==================================================
   // Register indices on the decoded serial register port
   localparam logic [7:0] A_CONFIG = 8'h00;
   localparam logic [7:0] A_COEFF = 8'h01;
   localparam logic [7:0] A_GAIN_A = 8'h02;
   localparam logic [7:0] A_GAIN_B = 8'h03;
   localparam logic [7:0] A_GAIN_C = 8'h04;
   localparam logic [7:0] A_HPF_OFF = 8'h05;
   localparam logic [7:0] A_SAMP_A = 8'h06;
   localparam logic [7:0] A_SAMP_B = 8'h07;
   localparam logic [7:0] A_SAMP_C = 8'h08;
   localparam logic [7:0] A_FLAGS = 8'h09;
   localparam logic [7:0] A_ENABLES = 8'h0A;
   // ==================================================
   // Field positions and reset values
   localparam int CFG_INT_ON = 0;
   localparam int CFG_SEL_A = 8;
   localparam int CFG_SEL_B = 10;
   localparam int CFG_SEL_C = 12;
   localparam int READY_BIT = 17;
   localparam int OVERRUN_BIT = 0;
   localparam logic [23:0] RST_COEFF = 24'h000000;
   localparam logic [23:0] RST_GAIN = 24'h000000;
   localparam logic [23:0] RST_HPF = 24'h000000;
   localparam logic [1:0] SEL_FIRST = 2'h1;
   localparam logic [1:0] SEL_SECOND = 2'h2;
   // ==================================================
   // Arithmetic scaling
   localparam int FRAC_BITS = 23;
   localparam int HPF_FRAC = 8;
   localparam int HPF_SHIFT = 10;
   localparam int INT_OUT_SHIFT = 8;
   localparam logic signed [63:0] UNITY = 64'sh800000;
   localparam logic signed [63:0] SAT_MAX = 64'sh7FFFFF;
   localparam logic signed [63:0] SAT_MIN = -64'sh800000;
   localparam int FIFO_DEPTH = 32;
   typedef struct packed {
      logic [23:0] va;
      logic [23:0] vb;
      logic [23:0] vc;
      logic [23:0] ia;
      logic [23:0] ib;
      logic [23:0] ic;
      logic [23:0] in;
   } pcd_word_t;
   localparam int WORD_W = $bits(pcd_word_t);
endpackage

// ---- pcd_stream_if.sv ----
// Valid/ready stream carrier between datapath and FIFO
`timescale 1ns/10ps
interface pcd_stream_if #(parameter int W = 8) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src(output valid, output data, input ready);
   modport snk(input valid, input data, output ready);
endinterface

// ---- phase_channel_datapath.sv ----
// Per-phase voltage and current sample datapath with register port
`timescale 1ns/10ps
// Summary of operation
// - Each phase and neutral current path has a digital integrator.
// - Integrator is off after reset; config bit 0 turns it on.
// - Coefficient is ignored while the integrator is off.
// - Coefficient reads back as 28-bit sign extension, top nibble zero.
// - Voltage paths deliver signed 24-bit samples at 8 kSPS.
// - Full-scale input swings between 0xA58AC0 and 0x5A7540.
// - Voltage is multiplied by one plus gain over 2^23.
// - Scaled voltage feeds every downstream result of its phase.
// - Gain registers read back as 28-bit sign extension, top nibble zero.
// - Each voltage path has a high-pass filter under the shared disable.
// - Filters run while the disable register is zero, else bypassed.
// - Filter output is captured at 8 kSPS into three sample registers.
// - Sample-ready flag bit 17 sets when new samples are readable.
// - Enable bit 17 set raises the interrupt with the ready flag.
// - Sample registers read as 32-bit sign-extended words.
// - Redirected voltage and own current form that phase's powers.
// - Phase A select: 00 A, 01 B, 10 C.
// - Phase A select 11 behaves as 00.
// - Phase B select: 00 B, 01 C, 10 A.
// - Phase B select 11 behaves as 00.
// - Phase C select: 00 C, 01 A, 10 B, 11 as 00.
module phase_channel_datapath #(
   parameter int SAMPLE_DIV = pcd_pkg::SAMPLE_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [23:0] adc_va,
   input wire logic [23:0] adc_vb,
   input wire logic [23:0] adc_vc,
   input wire logic [23:0] adc_ia,
   input wire logic [23:0] adc_ib,
   input wire logic [23:0] adc_ic,
   input wire logic [23:0] adc_in,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic sample_irq_n,
   output logic path_valid,
   input wire logic path_ready,
   output logic [23:0] path_va,
   output logic [23:0] path_vb,
   output logic [23:0] path_vc,
   output logic [23:0] path_ia,
   output logic [23:0] path_ib,
   output logic [23:0] path_ic,
   output logic [23:0] path_in
);
   typedef struct packed {
      pcd_pkg::pcd_div_t div;
      logic int_on;
      logic [1:0] sel_a;
      logic [1:0] sel_b;
      logic [1:0] sel_c;
      logic [23:0] coeff;
      logic [2:0][23:0] gain;
      logic [23:0] hpf_off;
      logic [2:0][23:0] wave;
      logic [2:0][39:0] dc;
      logic [3:0][39:0] integ;
      logic flag;
      logic mask;
      logic overrun;
      logic pend;
      pcd_pkg::pcd_word_t word;
      logic [31:0] rdata;
   } pcd_state_t;

   pcd_state_t r, next_r;
   logic tick;
   logic [2:0][23:0] vin;
   logic [3:0][23:0] iin;
   logic [3:0][23:0] cur;
   logic [2:0][23:0] wnew;

   pcd_stream_if #(.W(pcd_pkg::WORD_W)) push_s ();
   pcd_stream_if #(.W(pcd_pkg::WORD_W)) pop_s ();
   pcd_pkg::pcd_word_t pop_word;

   // ==================================================
   // Helpers
   function automatic logic signed [63:0] sx64(input logic [23:0] v);
      sx64 = {{40{v[23]}}, v};
   endfunction

   function automatic logic signed [63:0] sx40(input logic [39:0] v);
      sx40 = {{24{v[39]}}, v};
   endfunction

   // Clamp instead of wrap; a wrapped peak would flip sign downstream
   function automatic logic [23:0] sat24(input logic signed [63:0] v);
      if (v > pcd_pkg::SAT_MAX) begin
         sat24 = pcd_pkg::SAT_MAX[23:0];
      end else if (v < pcd_pkg::SAT_MIN) begin
         sat24 = pcd_pkg::SAT_MIN[23:0];
      end else begin
         sat24 = v[23:0];
      end
   endfunction

   // Voltage selector; code 11 falls back to the own voltage
   function automatic logic [23:0] sel_volt(input logic [1:0] code,
         input logic [23:0] own, input logic [23:0] first,
         input logic [23:0] second);
      case (code)
         pcd_pkg::SEL_FIRST: sel_volt = first;
         pcd_pkg::SEL_SECOND: sel_volt = second;
         default: sel_volt = own;
      endcase
   endfunction

   function automatic logic [31:0] rd28(input logic [23:0] v);
      rd28 = {4'h0, {4{v[23]}}, v};
   endfunction

   // ==================================================
   // Input grouping; converter words come from logic on ref_clk
   // full-scale codes pass unclipped
   assign vin = {adc_vc, adc_vb, adc_va};
   assign iin = {adc_in, adc_ic, adc_ib, adc_ia};
   assign tick = (r.div == pcd_pkg::pcd_div_t'(SAMPLE_DIV - 1));

   // ==================================================
   // Next-state logic
   always_comb begin
      logic signed [63:0] scaled;
      logic signed [63:0] dc64;
      logic signed [63:0] s64;
      logic signed [63:0] sn;
      logic [23:0] sv;
      logic hpf_on;
      scaled = '0;
      dc64 = '0;
      s64 = '0;
      sn = '0;
      sv = '0;
      hpf_on = 1'b0;
      next_r = r;
      wnew = r.wave;
      // Every current lane is assigned in the loop below
      cur = '0;
      next_r.div = tick ? '0 : r.div + 1'b1;
      hpf_on = (r.hpf_off == '0);
      for (int p = 0; p < 3; p++) begin
         scaled = (sx64(vin[p]) * (pcd_pkg::UNITY + sx64(r.gain[p])))
            >>> pcd_pkg::FRAC_BITS;
         sv = sat24(scaled);
         // dc offset removal by leaky average
         dc64 = sx40(r.dc[p]);
         if (hpf_on) begin
            wnew[p] = sat24(sx64(sv) - (dc64 >>> pcd_pkg::HPF_FRAC));
         end else begin
            wnew[p] = sv;
         end
         if (tick) begin
            next_r.wave[p] = wnew[p];
            if (hpf_on) begin
               next_r.dc[p] = 40'(dc64 + (((sx64(sv) <<< pcd_pkg::HPF_FRAC)
                  - dc64) >>> pcd_pkg::HPF_SHIFT));
            end else begin
               next_r.dc[p] = '0;
            end
         end
      end
      for (int c = 0; c < 4; c++) begin
         s64 = sx40(r.integ[c]);
         sn = s64 + sx64(iin[c]) + ((s64 * sx64(r.coeff)) >>> pcd_pkg::FRAC_BITS);
         if (r.int_on) begin
            cur[c] = sat24(sn >>> pcd_pkg::INT_OUT_SHIFT);
         end else begin
            cur[c] = iin[c];
         end
         if (tick) begin
            next_r.integ[c] = r.int_on ? sn[39:0] : '0;
         end
      end
      // Hand-off word; a stalled FIFO holds it, a new tick overwrites it
      if (tick) begin
         next_r.pend = 1'b1;
         next_r.overrun = r.overrun | (r.pend & ~push_s.ready);
         next_r.word.va = sel_volt(r.sel_a, wnew[0], wnew[1], wnew[2]);
         next_r.word.vb = sel_volt(r.sel_b, wnew[1], wnew[2], wnew[0]);
         next_r.word.vc = sel_volt(r.sel_c, wnew[2], wnew[0], wnew[1]);
         // own current stays with its phase
         next_r.word.ia = cur[0];
         next_r.word.ib = cur[1];
         next_r.word.ic = cur[2];
         next_r.word.in = cur[3];
      end else if (push_s.ready) begin
         next_r.pend = 1'b0;
      end
      // ready flag, set wins over clear
      next_r.flag = tick | (r.flag & ~(reg_wr & (reg_addr == pcd_pkg::A_FLAGS)
         & reg_wdata[pcd_pkg::READY_BIT]));
      if (reg_wr && reg_addr == pcd_pkg::A_FLAGS && reg_wdata[pcd_pkg::OVERRUN_BIT]
            && !(tick && r.pend && !push_s.ready)) begin
         next_r.overrun = 1'b0;
      end
      // Register writes take the low 24 bits of the word
      if (reg_wr) begin
         case (reg_addr)
            pcd_pkg::A_CONFIG: begin
               next_r.int_on = reg_wdata[pcd_pkg::CFG_INT_ON];
               next_r.sel_a = reg_wdata[pcd_pkg::CFG_SEL_A +: 2];
               next_r.sel_b = reg_wdata[pcd_pkg::CFG_SEL_B +: 2];
               next_r.sel_c = reg_wdata[pcd_pkg::CFG_SEL_C +: 2];
            end
            pcd_pkg::A_COEFF: next_r.coeff = reg_wdata[23:0];
            pcd_pkg::A_GAIN_A: next_r.gain[0] = reg_wdata[23:0];
            pcd_pkg::A_GAIN_B: next_r.gain[1] = reg_wdata[23:0];
            pcd_pkg::A_GAIN_C: next_r.gain[2] = reg_wdata[23:0];
            pcd_pkg::A_HPF_OFF: next_r.hpf_off = reg_wdata[23:0];
            pcd_pkg::A_ENABLES: next_r.mask = reg_wdata[pcd_pkg::READY_BIT];
            default: ;
         endcase
      end
      // Registered read answer; unmapped indices read zero
      if (reg_rd) begin
         next_r.rdata = '0;
         case (reg_addr)
            pcd_pkg::A_CONFIG: begin
               next_r.rdata[pcd_pkg::CFG_INT_ON] = r.int_on;
               next_r.rdata[pcd_pkg::CFG_SEL_A +: 2] = r.sel_a;
               next_r.rdata[pcd_pkg::CFG_SEL_B +: 2] = r.sel_b;
               next_r.rdata[pcd_pkg::CFG_SEL_C +: 2] = r.sel_c;
            end
            pcd_pkg::A_COEFF: next_r.rdata = rd28(r.coeff);
            pcd_pkg::A_GAIN_A: next_r.rdata = rd28(r.gain[0]);
            pcd_pkg::A_GAIN_B: next_r.rdata = rd28(r.gain[1]);
            pcd_pkg::A_GAIN_C: next_r.rdata = rd28(r.gain[2]);
            pcd_pkg::A_HPF_OFF: next_r.rdata = {8'h00, r.hpf_off};
            // samples sign extended to 32 bits
            pcd_pkg::A_SAMP_A: next_r.rdata = 32'(sx64(r.wave[0]));
            pcd_pkg::A_SAMP_B: next_r.rdata = 32'(sx64(r.wave[1]));
            pcd_pkg::A_SAMP_C: next_r.rdata = 32'(sx64(r.wave[2]));
            pcd_pkg::A_FLAGS: begin
               next_r.rdata[pcd_pkg::READY_BIT] = r.flag;
               next_r.rdata[pcd_pkg::OVERRUN_BIT] = r.overrun;
            end
            pcd_pkg::A_ENABLES: next_r.rdata[pcd_pkg::READY_BIT] = r.mask;
            default: ;
         endcase
      end
   end

   // State register; all control is off and all gains unity after reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r <= '0;
         r.coeff <= pcd_pkg::RST_COEFF;
         r.gain <= {3{pcd_pkg::RST_GAIN}};
         r.hpf_off <= pcd_pkg::RST_HPF;
      end else begin
         r <= next_r;
      end
   end

   // ==================================================
   // FIFO toward the power computation; stalls hold the pending word
   assign push_s.valid = r.pend;
   assign push_s.data = r.word;
   assign pop_s.ready = path_ready;

   pcd_fifo #(.W(pcd_pkg::WORD_W), .DEPTH(pcd_pkg::FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_s(push_s),
      .out_s(pop_s)
   );

   // scaled voltages feed all downstream results
   assign pop_word = pop_s.data;
   assign path_valid = pop_s.valid;
   assign path_va = pop_word.va;
   assign path_vb = pop_word.vb;
   assign path_vc = pop_word.vc;
   assign path_ia = pop_word.ia;
   assign path_ib = pop_word.ib;
   assign path_ic = pop_word.ic;
   assign path_in = pop_word.in;
   assign reg_rdata = r.rdata;
   assign sample_irq_n = ~(r.flag & r.mask);

   // ==================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_reset_defaults: assert property ($fell(rst) |-> !r.int_on
      && r.sel_a == '0 && r.hpf_off == '0 && r.coeff == '0)
      else $error("control not cleared by reset");
   a_int_bypass: assert property (tick && !r.int_on |=>
      r.word.ia == $past(adc_ia) && r.integ[0] == '0)
      else $error("current not passed raw with integrator off");
   a_gain_unity: assert property (tick && r.gain[0] == '0
      && r.hpf_off != '0 |=> r.wave[0] == $past(adc_va))
      else $error("unity gain or filter bypass broken");
   a_gain_clamp: assert property (tick && r.hpf_off != '0
      && !r.gain[1][23] && r.gain[1] >= 24'h400000
      && !adc_vb[23] && adc_vb >= 24'h5A0000 |=> r.wave[1] == 24'h7FFFFF)
      else $error("gain product not saturated");
   a_flag_set: assert property (tick |=> r.flag ##1 r.flag
      || $past(reg_wr, 1))
      else $error("ready flag not set on new samples");
   a_irq_raise: assert property (tick && r.mask
      && !(reg_wr && reg_addr == pcd_pkg::A_ENABLES) |=> !sample_irq_n)
      else $error("interrupt not raised with mask set");
   a_samp_sext: assert property (reg_rd && reg_addr == pcd_pkg::A_SAMP_A
      |=> reg_rdata == {{8{$past(r.wave[0][23])}}, $past(r.wave[0])})
      else $error("sample read not sign extended");
   a_gain_fmt: assert property (reg_rd && reg_addr == pcd_pkg::A_GAIN_C
      |=> reg_rdata[31:28] == 4'h0 && reg_rdata[27:24] == {4{reg_rdata[23]}})
      else $error("gain read format wrong");
   a_sel_a_route: assert property (tick && r.sel_a == 2'h2
      |=> r.word.va == r.wave[2])
      else $error("phase A selector wrong");
   a_sel_b_fold: assert property (tick && r.sel_b == 2'h3
      |=> r.word.vb == r.wave[1])
      else $error("phase B selector code 3 wrong");
   a_sel_c_route: assert property (tick && r.sel_c == 2'h1
      |=> r.word.vc == r.wave[0])
      else $error("phase C selector wrong");

   c_int_running: cover property (tick && r.int_on);
   c_fifo_full: cover property (push_s.valid && !push_s.ready);
   c_overrun: cover property ($rose(r.overrun));
   c_irq: cover property ($fell(sample_irq_n));
endmodule // phase_channel_datapath

// ---- phase_channel_datapath_tb_top.sv ----
// Self-checking bench for the phase channel datapath register port and stream
`timescale 1ns/10ps
module phase_channel_datapath_tb_top;
   // ==================================================
   // Signals
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [23:0] adc_va = 24'h100000;
   logic [23:0] adc_vb = 24'h100000;
   logic [23:0] adc_vc = 24'h100000;
   logic [23:0] adc_ia = 24'h012345;
   logic [23:0] adc_ib = 24'h020000;
   logic [23:0] adc_ic = 24'h030000;
   logic [23:0] adc_in = 24'h040000;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic sample_irq_n;
   logic path_valid;
   logic path_ready;
   logic [23:0] path_va, path_vb, path_vc, path_ia, path_ib, path_ic, path_in;
   logic stall = 1'b0;
   logic [31:0] d;
   int n_taken;
   int n0;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   // Short divider keeps each sample period at twenty clocks
   phase_channel_datapath #(.SAMPLE_DIV(20)) DUT (.ref_clk(ref_clk), .rst(rst),
      .adc_va(adc_va), .adc_vb(adc_vb), .adc_vc(adc_vc), .adc_ia(adc_ia), .adc_ib(adc_ib),
      .adc_ic(adc_ic), .adc_in(adc_in), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sample_irq_n(sample_irq_n), .path_valid(path_valid), .path_ready(path_ready),
      .path_va(path_va), .path_vb(path_vb), .path_vc(path_vc), .path_ia(path_ia),
      .path_ib(path_ib), .path_ic(path_ic), .path_in(path_in));
   pcd_far_model far (.ref_clk(ref_clk), .stall(stall), .path_valid(path_valid),
      .path_ready(path_ready), .n_taken(n_taken));
   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;
   // Hang guard, far above the few thousand cycles the tests need
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   // ==================================================
   // Tasks
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk1(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask
   // Strobes are one-cycle pulses launched and dropped on falling edges
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      @(negedge ref_clk);
      v = reg_rdata;
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk32(what, exp, v);
   endtask
   // Poll the ready flag, then clear it by writing one to it
   task automatic wait_ready(input int n);
      logic [31:0] f;
      int k;
      repeat (n) begin
         f = 32'h0;
         k = 0;
         while (f[pcd_pkg::READY_BIT] !== 1'b1 && k < 40) begin
            rd(pcd_pkg::A_FLAGS, f);
            k++;
         end
         chk1("ready flag", 1'b1, f[pcd_pkg::READY_BIT]); // flag sets
         wr(pcd_pkg::A_FLAGS, 32'h00020000);
      end
   endtask
   task automatic wait_word();
      int k;
      k = 0;
      @(negedge ref_clk);
      while (path_valid !== 1'b1 && k < 100) begin
         @(negedge ref_clk);
         k++;
      end
   endtask
   // Expected routing: 1 picks the first other phase, 2 the second, else own
   function automatic logic [23:0] pick(input logic [1:0] s, input logic [23:0] own,
      input logic [23:0] first, input logic [23:0] second);
      return (s == 2'h1) ? first : ((s == 2'h2) ? second : own);
   endfunction
   // ==================================================
   // Main sequence
   initial begin
      repeat (16) @(negedge ref_clk);
      rst = 1'b0;
      rchk("config", pcd_pkg::A_CONFIG, 32'h0); // integrator off
      rchk("coefficient", pcd_pkg::A_COEFF, 32'h0); // zero reset
      rchk("gain a", pcd_pkg::A_GAIN_A, 32'h0); // unity gain
      rchk("filter off", pcd_pkg::A_HPF_OFF, 32'h0); // filters on
      rchk("unmapped", 8'h3F, 32'h0);
      chk1("irq idle", 1'b1, sample_irq_n); // masked
      $display("test reset done");
      // Constant dc input must be pulled down by the running filter
      wait_ready(40);
      rd(pcd_pkg::A_SAMP_A, d);
      chk1("filtered dc", 1'b1, d[23:0] < 24'h100000); // offset removed
      wr(pcd_pkg::A_HPF_OFF, 32'h00000001);
      rchk("filter off", pcd_pkg::A_HPF_OFF, 32'h00000001); // nonzero bypass
      adc_va = 24'h5A7540;
      adc_vc = 24'hA58AC0;
      wait_ready(3);
      rchk("sample a", pcd_pkg::A_SAMP_A, 32'h005A7540); // positive peak
      rchk("sample b", pcd_pkg::A_SAMP_B, 32'h00100000); // capture
      rchk("sample c", pcd_pkg::A_SAMP_C, 32'hFFA58AC0); // sign extension
      $display("test samples done");
      // Every selector code on all three paths at once, 11 included
      for (int c = 0; c < 4; c++) begin
         wr(pcd_pkg::A_CONFIG, {18'h0, c[1:0], c[1:0], c[1:0], 8'h00});
         wait_ready(3);
         wait_word();
         chk32("path a", {8'h0, pick(c[1:0], adc_va, adc_vb, adc_vc)}, {8'h0, path_va});
         chk32("path b", {8'h0, pick(c[1:0], adc_vb, adc_vc, adc_va)}, {8'h0, path_vb});
         chk32("path c", {8'h0, pick(c[1:0], adc_vc, adc_va, adc_vb)}, {8'h0, path_vc});
         chk32("path ia", {8'h0, adc_ia}, {8'h0, path_ia}); // own current
         chk32("path ib", {8'h0, adc_ib}, {8'h0, path_ib}); // own current
         chk32("path ic", {8'h0, adc_ic}, {8'h0, path_ic}); // own current
         chk32("path in", {8'h0, adc_in}, {8'h0, path_in}); // neutral path
      end
      $display("test selector done");
      wr(pcd_pkg::A_CONFIG, 32'h0);
      wr(pcd_pkg::A_COEFF, 32'h0FFF8000); // load before enable
      rchk("coefficient", pcd_pkg::A_COEFF, 32'h0FFF8000); // padded word
      wr(pcd_pkg::A_GAIN_B, 32'h00400000);
      wr(pcd_pkg::A_GAIN_C, 32'h00C00000);
      rchk("gain b", pcd_pkg::A_GAIN_B, 32'h00400000); // padded word
      rchk("gain c", pcd_pkg::A_GAIN_C, 32'h0FC00000); // sign to 28 bits
      wait_ready(3);
      rchk("sample b", pcd_pkg::A_SAMP_B, 32'h00180000); // plus half
      rchk("sample c", pcd_pkg::A_SAMP_C, 32'hFFD2C560); // minus half
      wait_word();
      chk32("path b", 32'h00180000, {8'h0, path_vb}); // scaled feeds path
      chk32("path ia", {8'h0, adc_ia}, {8'h0, path_ia}); // coefficient unused
      adc_vb = 24'h5A7540;
      wait_ready(3);
      rchk("sample b", pcd_pkg::A_SAMP_B, 32'h007FFFFF); // clipped
      $display("test gain done");
      // Interrupt follows the flag only while its enable is set
      wr(pcd_pkg::A_ENABLES, 32'h00020000);
      wait_ready(1);
      repeat (25) @(negedge ref_clk);
      chk1("irq low", 1'b0, sample_irq_n); // enabled
      wr(pcd_pkg::A_ENABLES, 32'h0);
      repeat (2) @(negedge ref_clk);
      chk1("irq masked", 1'b1, sample_irq_n); // masked
      $display("test interrupt done");
      wr(pcd_pkg::A_CONFIG, 32'h00000001);
      rchk("config", pcd_pkg::A_CONFIG, 32'h00000001); // enable bit
      wait_ready(5);
      wait_word();
      chk1("integrated", 1'b1, path_ia != adc_ia); // integrator acts
      chk1("integrated n", 1'b1, path_in != adc_in); // neutral integrator
      $display("test integrator done");
      // Stall far side past 32 words, then drain until empty
      stall = 1'b1;
      wait_ready(40);
      n0 = n_taken;
      rd(pcd_pkg::A_FLAGS, d);
      chk1("overrun", 1'b1, d[pcd_pkg::OVERRUN_BIT]);
      chk1("full held", 1'b1, path_valid);
      stall = 1'b0;
      repeat (60) @(negedge ref_clk);
      chk1("drained", 1'b1, (n_taken - n0) >= 32);
      for (int k = 0; k < 40 && path_valid !== 1'b0; k++) begin
         @(negedge ref_clk);
      end
      chk1("empty", 1'b0, path_valid);
      $display("test buffer done");
      print_verdict();
   end
endmodule // phase_channel_datapath_tb_top
